// ==== logic/isp_bus_if.sv ====
// isp_bus_if: the two open-drain wires between host master and slave port.
// assumes pull-ups on both lines; the wired-and is resolved here.
`timescale 1ns/1ps
`default_nettype none

interface isp_bus_if;
  // master drives
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  // slave drives data only, never the clock
  logic sda_s_o;
  logic sda_s_oe;
  // resolved line levels, high when nobody pulls low
  wire logic scl;
  wire logic sda;

  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport master (
    output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
    input scl, sda
  );

  modport slave (
    output sda_s_o, sda_s_oe,
    input scl, sda
  );
endinterface : isp_bus_if

`default_nettype wire

// ==== logic/isp_master.sv ====
// isp_master: the host end, a two-wire bus master moving one byte per
// command, with optional start before and stop after the byte.
// assumes no clock stretching; scl is made here from clk_sys_i by a divider.
`timescale 1ns/1ps
`default_nettype none

module isp_master (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // two-wire link
  isp_bus_if.master bus,
  // byte command, taken when valid and ready
  input wire logic cmd_valid_i,
  input wire logic cmd_start_i,
  input wire logic cmd_stop_i,
  input wire logic cmd_read_i,
  input wire logic cmd_last_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic cmd_ready_o,
  // byte result
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_nack_o
);

  typedef enum logic [2:0] {
    M_IDLE,
    M_HOLD,
    M_START,
    M_BIT,
    M_STOP
  } isp_mst_t;

  // sda synchroniser
  logic [2:0] sda_sh_q, sda_sh_d;
  logic sda_q, sda_d;

  always_comb begin
    sda_sh_d = {sda_sh_q[1:0], bus.sda};
    sda_d = (sda_sh_q[1] == sda_sh_q[2]) ? sda_sh_q[2] : sda_q;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_sh_q <= isp_pkg::SYNC_RST;
      sda_q <= 1'b1;
    end else begin
      sda_sh_q <= sda_sh_d;
      sda_q <= sda_d;
    end
  end

  isp_mst_t st_q, st_d;
  logic [7:0] qcnt_q, qcnt_d;
  logic [2:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic rd_q, rd_d, last_q, last_d, stop_q, stop_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic ready_q, ready_d;
  logic rsp_valid_q, rsp_valid_d, rsp_nack_q, rsp_nack_d;
  logic [7:0] rsp_data_q, rsp_data_d;
  logic tick;

  assign tick = (qcnt_q == 8'(isp_pkg::T_QTR_CYC - 1));

  always_comb begin
    st_d = st_q;
    qcnt_d = 8'h00;
    ph_d = ph_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rd_d = rd_q;
    last_d = last_q;
    stop_d = stop_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    ready_d = ready_q;
    rsp_valid_d = 1'b0;
    rsp_nack_d = rsp_nack_q;
    rsp_data_d = rsp_data_q;

    if (st_q == M_START || st_q == M_BIT || st_q == M_STOP) begin
      qcnt_d = tick ? 8'h00 : qcnt_q + 8'h01;
    end

    unique case (st_q)
      M_IDLE, M_HOLD: begin
        if (cmd_valid_i && ready_q) begin
          ready_d = 1'b0;
          ph_d = 3'h0;
          bit_d = 4'h0;
          sh_d = cmd_wdata_i;
          rd_d = cmd_read_i;
          last_d = cmd_last_i;
          stop_d = cmd_stop_i;
          // a free bus always begins with a start
          st_d = (cmd_start_i || st_q == M_IDLE) ? M_START : M_BIT;
        end
      end
      M_START: begin
        if (tick) begin
          ph_d = ph_q + 3'h1;
          unique case (ph_q)
            isp_pkg::PH_SDA_REL: sda_oe_d = 1'b0;
            isp_pkg::PH_SCL_REL: scl_oe_d = 1'b0;
            isp_pkg::PH_SDA_EDGE: sda_oe_d = 1'b1;
            isp_pkg::PH_SEQ_END: begin
              scl_oe_d = 1'b1;
              ph_d = 3'h0;
              st_d = M_BIT;
            end
            default: ;
          endcase
        end
      end
      M_BIT: begin
        if (tick) begin
          ph_d = ph_q + 3'h1;
          unique case (ph_q)
            isp_pkg::PH_BIT_DRV: begin
              // scl is low here, so data may change
              if (bit_q == isp_pkg::ACK_BIT_IDX) begin
                sda_oe_d = rd_q & ~last_q;
              end else begin
                sda_oe_d = ~rd_q & ~sh_q[7];
              end
            end
            isp_pkg::PH_BIT_SCLH: scl_oe_d = 1'b0;
            isp_pkg::PH_BIT_END: begin
              scl_oe_d = 1'b1;
              ph_d = 3'h0;
              if (bit_q == isp_pkg::ACK_BIT_IDX) begin
                rsp_valid_d = 1'b1;
                rsp_data_d = sh_q;
                rsp_nack_d = sda_q;
                st_d = stop_q ? M_STOP : M_HOLD;
                ready_d = ~stop_q;
              end else begin
                sh_d = {sh_q[6:0], sda_q};
                bit_d = bit_q + 4'h1;
              end
            end
            default: ;
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          ph_d = ph_q + 3'h1;
          unique case (ph_q)
            isp_pkg::PH_SDA_REL: sda_oe_d = 1'b1;
            isp_pkg::PH_SCL_REL: scl_oe_d = 1'b0;
            isp_pkg::PH_SDA_EDGE: sda_oe_d = 1'b0;
            // two quarters of bus free time before the next start
            isp_pkg::PH_SEQ_END: begin
              ph_d = 3'h0;
              ready_d = 1'b1;
              st_d = M_IDLE;
            end
            default: ;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= M_IDLE;
      qcnt_q <= 8'h00;
      ph_q <= 3'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      last_q <= 1'b0;
      stop_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_nack_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      st_q <= st_d;
      qcnt_q <= qcnt_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      last_q <= last_d;
      stop_q <= stop_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_nack_q <= rsp_nack_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  // open drain on both lines
  assign bus.scl_m_o = 1'b0;
  assign bus.sda_m_o = 1'b0;
  assign bus.scl_m_oe = scl_oe_q;
  assign bus.sda_m_oe = sda_oe_q;

  assign cmd_ready_o = ready_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o = rsp_data_q;
  assign rsp_nack_o = rsp_nack_q;

endmodule : isp_master

`default_nettype wire

// ==== logic/isp_pkg.sv ====
// isp_pkg: constants shared by both ends of the two-wire slave host port.
// assumes a 100 MHz system clock on both ends.
`default_nettype none

package isp_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 10;

  // address layout
  localparam logic [3:0] ADDR_UPPER_DEF = 4'h5;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam int ADDR_RW_POS = 0;

  // bit counting within one byte
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;

  // bus free time after a stop, least time, rounded up
  localparam int T_BUF_NS = 4700;
  localparam int T_BUF_CYC = (T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // one quarter of the master's scl period, rounded up
  localparam int T_QTR_NS = 2500;
  localparam int T_QTR_CYC = (T_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // quarter phases of the master's start and stop sequences
  localparam logic [2:0] PH_SDA_REL = 3'h0;
  localparam logic [2:0] PH_SCL_REL = 3'h1;
  localparam logic [2:0] PH_SDA_EDGE = 3'h3;
  localparam logic [2:0] PH_SEQ_END = 3'h5;

  // quarter phases of one master bit slot
  localparam logic [2:0] PH_BIT_DRV = 3'h0;
  localparam logic [2:0] PH_BIT_SCLH = 3'h1;
  localparam logic [2:0] PH_BIT_END = 3'h3;

  // reset level of a synchronised bus line (pulled up)
  localparam logic [2:0] SYNC_RST = 3'h7;

endpackage : isp_pkg

`default_nettype wire

// ==== logic/isp_slave.sv ====
// isp_slave: the device end, a two-wire slave taking bytes from the host
// and returning bytes from the user side.
// assumes the host is the only master; the link lines are asynchronous
// to clk_sys_i and are filtered through three flip-flops each.
`timescale 1ns/1ps
`default_nettype none

module isp_slave #(
  parameter logic [3:0] ADDR_UPPER = isp_pkg::ADDR_UPPER_DEF
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // two-wire link
  isp_bus_if.slave bus,
  // address strap
  input wire logic [2:0] slave_address_select_pins_i,
  // byte to return on a read, taken on tx_take_o
  input wire logic [7:0] tx_data_i,
  // user side status
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic tx_take_o,
  output logic addr_hit_o,
  output logic read_mode_o,
  output logic nack_o,
  output logic busy_o
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_ACK,
    S_TX,
    S_MACK
  } isp_sst_t;

  // line synchronisers
  logic [2:0] scl_sh_q, scl_sh_d;
  logic [2:0] sda_sh_q, sda_sh_d;
  logic scl_q, scl_d, scl_p_q;
  logic sda_q, sda_d, sda_p_q;

  always_comb begin
    scl_sh_d = {scl_sh_q[1:0], bus.scl};
    sda_sh_d = {sda_sh_q[1:0], bus.sda};
    // a new level counts once the second and third stages agree
    scl_d = (scl_sh_q[1] == scl_sh_q[2]) ? scl_sh_q[2] : scl_q;
    sda_d = (sda_sh_q[1] == sda_sh_q[2]) ? sda_sh_q[2] : sda_q;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_sh_q <= isp_pkg::SYNC_RST;
      sda_sh_q <= isp_pkg::SYNC_RST;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_sh_q <= scl_sh_d;
      sda_sh_q <= sda_sh_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end

  // line events
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [6:0] own_addr;

  assign scl_rise = scl_q & ~scl_p_q;
  assign scl_fall = ~scl_q & scl_p_q;
  // scl must be high on both samples so a clock edge is not mistaken
  assign start_ev = ~sda_q & sda_p_q & scl_q & scl_p_q;
  assign stop_ev = sda_q & ~sda_p_q & scl_q & scl_p_q;
  assign own_addr = {ADDR_UPPER, slave_address_select_pins_i};

  // protocol state
  isp_sst_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic is_addr_q, is_addr_d;
  logic [7:0] sh_q, sh_d;
  logic sda_oe_q, sda_oe_d;
  logic rw_q, rw_d;
  logic [7:0] rx_data_q, rx_data_d;
  logic rx_valid_q, rx_valid_d;
  logic tx_take_q, tx_take_d;
  logic addr_hit_q, addr_hit_d;
  logic nack_q, nack_d;
  logic busy_q, busy_d;
  logic buf_run_q, buf_run_d;
  logic [8:0] buf_cnt_q, buf_cnt_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    done_d = done_q;
    is_addr_d = is_addr_q;
    sh_d = sh_q;
    sda_oe_d = sda_oe_q;
    rw_d = rw_q;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    tx_take_d = 1'b0;
    addr_hit_d = 1'b0;
    nack_d = 1'b0;
    busy_d = busy_q;
    buf_run_d = buf_run_q;
    buf_cnt_d = buf_cnt_q;

    unique case (st_q)
      S_IDLE: begin
      end
      S_RX: begin
        if (scl_rise) begin
          // sample while scl high
          sh_d = {sh_q[6:0], sda_q};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == isp_pkg::LAST_DATA_BIT) begin
            done_d = 1'b1;
          end
        end else if (scl_fall && done_q) begin
          done_d = 1'b0;
          is_addr_d = 1'b0;
          if (is_addr_q) begin
            if (sh_q[7:1] == own_addr &&
                sh_q[7:1] != isp_pkg::GEN_CALL_ADDR) begin
              sda_oe_d = 1'b1;
              rw_d = sh_q[isp_pkg::ADDR_RW_POS];
              addr_hit_d = 1'b1;
              st_d = S_ACK;
            end else begin
              // not ours: stay off the bus until the next start
              st_d = S_IDLE;
            end
          end else begin
            rx_data_d = sh_q;
            rx_valid_d = 1'b1;
            sda_oe_d = 1'b1;
            st_d = S_ACK;
          end
        end
      end
      S_ACK: begin
        // the ninth clock ends on its falling edge
        if (scl_fall) begin
          cnt_d = 3'h0;
          if (rw_q) begin
            sh_d = tx_data_i;
            tx_take_d = 1'b1;
            sda_oe_d = ~tx_data_i[7];
            st_d = S_TX;
          end else begin
            sda_oe_d = 1'b0;
            st_d = S_RX;
          end
        end
      end
      S_TX: begin
        if (scl_rise) begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == isp_pkg::LAST_DATA_BIT) begin
            done_d = 1'b1;
          end
        end else if (scl_fall) begin
          if (done_q) begin
            done_d = 1'b0;
            sda_oe_d = 1'b0;
            st_d = S_MACK;
          end else begin
            sh_d = {sh_q[6:0], 1'b0};
            sda_oe_d = ~sh_q[6];
          end
        end
      end
      S_MACK: begin
        if (scl_rise) begin
          if (sda_q) begin
            // master declined more data
            nack_d = 1'b1;
            st_d = S_IDLE;
          end
        end else if (scl_fall) begin
          cnt_d = 3'h0;
          sh_d = tx_data_i;
          tx_take_d = 1'b1;
          sda_oe_d = ~tx_data_i[7];
          st_d = S_TX;
        end
      end
    endcase

    // bus free timer after a stop
    if (buf_run_q) begin
      if (buf_cnt_q == 9'(isp_pkg::T_BUF_CYC - 1)) begin
        buf_run_d = 1'b0;
        busy_d = 1'b0;
      end else begin
        buf_cnt_d = buf_cnt_q + 9'h001;
      end
    end

    // start and stop override any state
    if (start_ev) begin
      st_d = S_RX;
      is_addr_d = 1'b1;
      cnt_d = 3'h0;
      done_d = 1'b0;
      sda_oe_d = 1'b0;
      busy_d = 1'b1;
      buf_run_d = 1'b0;
      buf_cnt_d = 9'h000;
    end else if (stop_ev) begin
      st_d = S_IDLE;
      done_d = 1'b0;
      sda_oe_d = 1'b0;
      buf_run_d = 1'b1;
      buf_cnt_d = 9'h000;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= S_IDLE;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
      is_addr_q <= 1'b0;
      sh_q <= 8'h00;
      sda_oe_q <= 1'b0;
      rw_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      tx_take_q <= 1'b0;
      addr_hit_q <= 1'b0;
      nack_q <= 1'b0;
      busy_q <= 1'b0;
      buf_run_q <= 1'b0;
      buf_cnt_q <= 9'h000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      is_addr_q <= is_addr_d;
      sh_q <= sh_d;
      sda_oe_q <= sda_oe_d;
      rw_q <= rw_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      tx_take_q <= tx_take_d;
      addr_hit_q <= addr_hit_d;
      nack_q <= nack_d;
      busy_q <= busy_d;
      buf_run_q <= buf_run_d;
      buf_cnt_q <= buf_cnt_d;
    end
  end

  // open drain: only ever pulls low, never touches scl
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_oe_q;

  assign rx_data_o = rx_data_q;
  assign rx_valid_o = rx_valid_q;
  assign tx_take_o = tx_take_q;
  assign addr_hit_o = addr_hit_q;
  assign read_mode_o = rw_q;
  assign nack_o = nack_q;
  assign busy_o = busy_q;

endmodule : isp_slave

`default_nettype wire

// ==== verif/i2c_slave_host_port_test.sv ====
// i2c_slave_host_port_test: host master and slave port joined back to back.
// assumes the slave keeps its default upper address bits.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_host_port_test;
  typedef struct packed {
    logic nack;
    logic [7:0] data;
  } isp_exp_t;

  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] pins = 3'h0;
  logic [7:0] tx_data = 8'h00;
  logic cmd_valid = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_stop = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_last = 1'b0;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_nack;
  logic [7:0] rsp_data;
  logic [7:0] rx_data;
  logic rx_valid;
  logic tx_take;
  logic addr_hit;
  logic read_mode;
  logic nack_pulse;
  logic busy;
  int n_errors = 0;
  int checked = 0;
  int n_hit = 0;
  int n_nk = 0;
  int n_take = 0;
  isp_exp_t exp_q[$];
  logic [7:0] rx_q[$];
  isp_exp_t e;
  logic [7:0] own;
  logic [7:0] d;

  isp_bus_if bus_if ();

  isp_slave u_isp_slave (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(bus_if),
    .slave_address_select_pins_i(pins), .tx_data_i(tx_data),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .tx_take_o(tx_take),
    .addr_hit_o(addr_hit), .read_mode_o(read_mode), .nack_o(nack_pulse),
    .busy_o(busy)
  );

  isp_master u_isp_master (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(bus_if),
    .cmd_valid_i(cmd_valid), .cmd_start_i(cmd_start), .cmd_stop_i(cmd_stop),
    .cmd_read_i(cmd_read), .cmd_last_i(cmd_last), .cmd_wdata_i(cmd_wdata),
    .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack)
  );

  isp_bus_properties u_isp_bus_properties (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .scl_m_o(bus_if.scl_m_o), .scl_m_oe(bus_if.scl_m_oe),
    .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe),
    .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe),
    .scl(bus_if.scl), .sda(bus_if.sda)
  );

  task automatic check(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // one byte command; valid is dropped at the taking edge
  task automatic xfer(input logic st, input logic sp, input logic rd,
                      input logic [7:0] wd, input logic nk, input logic [7:0] ed);
    int n;
    @(posedge clk_sys_i);
    cmd_start <= st;
    cmd_stop <= sp;
    cmd_read <= rd;
    cmd_last <= rd & nk;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    exp_q.push_back('{nack: nk, data: ed});
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (cmd_ready !== 1'b1 && n < 30000);
    cmd_valid <= 1'b0;
  endtask : xfer

  // waits out the bus free time after the closing stop
  task automatic settle();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || cmd_ready !== 1'b1) && n < 30000) begin
      @(posedge clk_sys_i);
      n++;
    end
    repeat (isp_pkg::T_BUF_CYC) @(posedge clk_sys_i);
    check("busy idle", 9'(busy), 9'h0);
    check("lines", 9'({bus_if.scl, bus_if.sda}), 9'h3);
  endtask : settle

  always @(posedge clk_sys_i) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare response", 9'h1, 9'h0);
      end else begin
        e = exp_q.pop_front();
        check("rsp_nack", 9'(rsp_nack), 9'(e.nack));
        check("rsp_data", 9'(rsp_data), 9'(e.data));
        check("busy", 9'(busy), 9'h1);
      end
    end
    if (rx_valid === 1'b1) begin
      if (rx_q.size() == 0) begin
        check("spare rx", 9'h1, 9'h0);
      end else begin
        check("rx_data", 9'(rx_data), 9'(rx_q.pop_front()));
      end
    end
    if (addr_hit === 1'b1) begin
      n_hit++;
    end
    if (nack_pulse === 1'b1) begin
      n_nk++;
    end
    if (tx_take === 1'b1) begin
      n_take++;
    end
  end

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // a hung handshake ends the run here
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    n_errors++;
    close_out();
  end

  initial begin
    void'($urandom(32'h6fc8ba76));
    @(posedge clk_sys_i);
    pins <= 3'($urandom);
    tx_data <= 8'($urandom);
    repeat (19) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    own = {isp_pkg::ADDR_UPPER_DEF, pins, 1'b0};
    // write: address then two data bytes, stop on the last
    xfer(1'b1, 1'b0, 1'b0, own, 1'b0, own);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      rx_q.push_back(d);
      xfer(1'b0, i == 1, 1'b0, d, 1'b0, d);
    end
    settle();
    // wrong low address bits are refused
    d = own ^ {4'h0, 3'($urandom_range(1, 7)), 1'b0};
    xfer(1'b1, 1'b1, 1'b0, d, 1'b1, d);
    settle();
    d = {isp_pkg::GEN_CALL_ADDR, 1'b0};
    xfer(1'b1, 1'b1, 1'b0, d, 1'b1, d);
    settle();
    // read one byte, nacked by the master as the last
    xfer(1'b1, 1'b0, 1'b0, own | 8'h01, 1'b0, own | 8'h01);
    xfer(1'b0, 1'b1, 1'b1, 8'h00, 1'b1, tx_data);
    settle();
    check("address hits", 9'(n_hit), 9'h2);
    check("read mode", 9'(read_mode), 9'h1);
    check("master nacks", 9'(n_nk), 9'h1);
    check("bytes loaded", 9'(n_take), 9'h1);
    check("rx left", 9'(rx_q.size()), 9'h0);
    close_out();
  end
endmodule : i2c_slave_host_port_test

`default_nettype wire

// ==== verif/isp_bus_properties.sv ====
// isp_bus_properties: timing and drive checks on the two-wire link.
// assumes both ends share clk_sys_i; takes the link signals as inputs.
`timescale 1ns/1ps
`default_nettype none

module isp_bus_properties (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // line drivers
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  // resolved lines
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic scl_d;
  logic sda_q;
  logic sda_d;
  logic [11:0] low_q;
  logic [11:0] low_d;
  logic [11:0] high_q;
  logic [11:0] high_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;

  // the low and high time counters saturate so a long idle bus cannot wrap them
  always_comb begin
    scl_d = scl;
    sda_d = sda;
    low_d = low_q;
    high_d = high_q;
    if (scl) begin
      low_d = 12'h000;
      if (high_q != 12'hfff) begin
        high_d = high_q + 12'h001;
      end
    end else begin
      high_d = 12'h000;
      if (low_q != 12'hfff) begin
        low_d = low_q + 12'h001;
      end
    end
    bit_d = bit_q;
    // start and stop both close a frame's byte count
    if (scl && scl_q && (sda_q != sda)) begin
      bit_d = 4'h0;
    end else if (scl && !scl_q) begin
      bit_d = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      low_q <= 12'h000;
      high_q <= 12'h000;
      bit_q <= 4'h0;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      low_q <= low_d;
      high_q <= high_d;
      bit_q <= bit_d;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence

  AST_OPEN_DRAIN: assert property (
    !scl_m_o && !sda_m_o && !sda_s_o)
    else $error("a line is driven high");
  AST_IDLE_HIGH: assert property (
    !scl_m_oe && !sda_m_oe && !sda_s_oe |-> scl && sda)
    else $error("released lines not high");
  AST_SLAVE_EDGE: assert property (
    $changed(sda_s_oe) |-> !scl && low_q inside {[12'd2:12'd8]})
    else $error("slave sda change outside low phase start");
  AST_DATA_STABLE: assert property (
    (start_s or stop_s) |-> high_q >= 12'd400)
    else $error("sda changed early in scl high phase");
  AST_START_HOLD: assert property (
    start_s |-> ##1 (scl && !sda && !sda_s_oe)[*8])
    else $error("start not held");
  AST_STOP_IDLE: assert property (
    stop_s |-> !sda_s_oe ##1
      (scl && sda && !scl_m_oe && !sda_m_oe)[*8])
    else $error("bus not idle after stop");
  AST_ACK_ONE_DRIVER: assert property (
    scl && !scl_q && bit_q == 4'h8 |-> !(sda_m_oe && sda_s_oe))
    else $error("both ends drive the acknowledge");
  // the scl release that sets up a stop counts as one rise
  AST_WHOLE_BYTES: assert property (
    (start_s or stop_s) |-> bit_q <= 4'h1)
    else $error("frame ended inside a byte");
  AST_SCL_LOW: assert property ($rose(scl) |-> low_q >= 12'd470)
    else $error("scl low phase too short");
  AST_SCL_HIGH: assert property ($fell(scl) |-> high_q >= 12'd400)
    else $error("scl high phase too short");
endmodule : isp_bus_properties

`default_nettype wire
